// ===== hw/bmd_pkg.sv
/*
  Constants and types shared by the single-bit instruction decoder and its
  quarter-phase generator: opcode field layout, opcode codes, phase and
  operation encodings, reset values and timing figures.
  Assumes a single core clock (ref_clk) that is the oscillator time base.
*/
// Summary of operation
// (RQ1) Opcode 0101 sets bit b of register f
// (RQ2) Opcode 0110 tests bit, skips if clear
// (RQ3) Tested bit one: single cycle, next runs
// (RQ4) Tested bit zero: next discarded, NOP executes
// (RQ5) Set/clear: decode, read, modify, write by quarters
// (RQ6) Test writes nothing; skip cycle does nothing
// (RQ7) Instruction cycle is four oscillator periods
// (RQ8) Fully static logic; clock may stop safely
// (RQ9) Bit instructions leave C, DC, Z unchanged
// (RQ10) Opcode 0100 clears bit b of register f
package bmd_pkg;

  // Widths of the instruction word and its fields
  localparam int OPC_W = 14;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int DATA_W = 8;

  // Field positions inside the 14-bit opcode
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 10;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int ADDR_HI = 6;
  localparam int ADDR_LO = 0;

  // Top-four-bit codes of the three instructions
  localparam logic [3:0] OPC_CLEAR = 4'h4;
  localparam logic [3:0] OPC_SET = 4'h5;
  localparam logic [3:0] OPC_TEST = 4'h6;

  // Timing: quarter-phases per instruction cycle and the oscillator period
  localparam int QUARTERS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCY_NS = QUARTERS * CLK_PERIOD_NS;

  // Quarter-phase states, one-hot
  typedef enum logic [3:0] {
    QP_ONE = 4'h1,
    QP_TWO = 4'h2,
    QP_THREE = 4'h4,
    QP_FOUR = 4'h8
  } bmd_phase_t;

  // Decoded operation, one-hot
  typedef enum logic [3:0] {
    OPK_NONE = 4'h1,
    OPK_CLEAR = 4'h2,
    OPK_SET = 4'h4,
    OPK_TEST = 4'h8
  } bmd_op_t;

  // Reset values
  localparam bmd_phase_t PHASE_RST = QP_FOUR;
  localparam bmd_op_t OP_RST = OPK_NONE;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [BIT_W-1:0] BIT_RST = 3'h0;

endpackage

// ===== hw/bmd_phase_gen.sv
/*
  Quarter-phase generator: rotates a one-hot phase through the four
  quarters of an instruction cycle, one quarter per ref_clk period.
  Assumes ref_clk is the oscillator time base and resetn is synchronous.
*/
`timescale 1ns/1ps
module bmd_phase_gen (
  input wire logic ref_clk,
  input wire logic resetn,
  output bmd_pkg::bmd_phase_t quarter_phase
);

  // Whole state of this module
  typedef struct packed {
    bmd_pkg::bmd_phase_t phase;
  } bmd_pg_state_t;

  bmd_pg_state_t st_r; // Registered state
  bmd_pg_state_t st_nxt; // Next state

  // Advance one quarter every oscillator period
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.phase)
      bmd_pkg::QP_ONE: st_nxt.phase = bmd_pkg::QP_TWO; // RQ7
      bmd_pkg::QP_TWO: st_nxt.phase = bmd_pkg::QP_THREE;
      bmd_pkg::QP_THREE: st_nxt.phase = bmd_pkg::QP_FOUR;
      bmd_pkg::QP_FOUR: st_nxt.phase = bmd_pkg::QP_ONE;
      // Only reachable from a corrupted code; restart the cycle cleanly
      default: st_nxt.phase = bmd_pkg::QP_ONE;
    endcase
  end

  // Plain edge-triggered flops, no dynamic storage, so a stopped clock loses nothing
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_r <= '{phase: bmd_pkg::PHASE_RST}; // RQ8
    else
      st_r <= st_nxt;
  end

  assign quarter_phase = st_r.phase;

  // Quarter one returns exactly four periods later
  a_phase_period: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ7
    (st_r.phase == bmd_pkg::QP_ONE) |-> ##1 (st_r.phase == bmd_pkg::QP_TWO)
      ##1 (st_r.phase == bmd_pkg::QP_THREE) ##1 (st_r.phase == bmd_pkg::QP_FOUR)
      ##1 (st_r.phase == bmd_pkg::QP_ONE))
    else $error("quarter-phase sequence broken");

endmodule // bmd_phase_gen

// ===== hw/bmd_decode.sv
/*
  Decode and execute for the single-bit instructions: clear bit, set bit,
  and test bit with skip if clear. Works quarter by quarter on a fetched
  14-bit opcode and a register file with a same-cycle read port.
  Assumes instr_word is stable from the fetch stage through quarter one,
  rf_rd_data answers rf_addr in the same cycle while rf_rd_en is high,
  and rf_wr_en/rf_wr_data are written at the end of the cycle they show.
*/
`timescale 1ns/1ps
module bmd_decode (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] rf_rd_data,
  output logic [6:0] rf_addr,
  output logic rf_rd_en,
  output logic rf_wr_en,
  output logic [7:0] rf_wr_data,
  output logic flags_hold,
  output logic bit_op_busy,
  output logic skip_nop,
  output bmd_pkg::bmd_phase_t quarter_phase
);

  // Whole state of the decoder
  typedef struct packed {
    bmd_pkg::bmd_op_t op; // Operation in flight
    logic [bmd_pkg::BIT_W-1:0] bit_idx; // Selected bit
    logic [bmd_pkg::ADDR_W-1:0] addr; // Register address
    logic [bmd_pkg::DATA_W-1:0] data; // Value read in quarter two
    logic rd_en; // Read strobe, shown in quarter two
    logic wr_en; // Write strobe, shown in quarter four
    logic [bmd_pkg::DATA_W-1:0] wr_data; // Modified value
    logic skip_pend; // Next fetched word must be discarded
    logic skip_nop; // Current cycle is a forced NOP
    logic flags_hold; // Tells the ALU to keep C, DC and Z
    logic busy; // A bit instruction is in flight; own flop so the pin is registered
  } bmd_state_t;

  bmd_state_t st_r; // Registered state
  bmd_state_t st_nxt; // Next state
  bmd_pkg::bmd_phase_t phase; // Current quarter from the generator

  // One-hot mask for a bit index; used by set, clear and test
  function automatic logic [bmd_pkg::DATA_W-1:0] bmd_bit_mask(
    input logic [bmd_pkg::BIT_W-1:0] idx);
    bmd_bit_mask = 8'h01 << idx;
  endfunction

  // Opcode class from the top four bits
  function automatic bmd_pkg::bmd_op_t bmd_op_decode(input logic [3:0] code);
    if (code == bmd_pkg::OPC_CLEAR)
      bmd_op_decode = bmd_pkg::OPK_CLEAR; // RQ10
    else if (code == bmd_pkg::OPC_SET)
      bmd_op_decode = bmd_pkg::OPK_SET; // RQ1
    else if (code == bmd_pkg::OPC_TEST)
      bmd_op_decode = bmd_pkg::OPK_TEST; // RQ2
    else
      bmd_op_decode = bmd_pkg::OPK_NONE;
  endfunction

  // Quarter-phase source
  bmd_phase_gen u_phase (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .quarter_phase(phase)
  );

  // Next-state logic, stepped by quarter
  always_comb
  begin
    st_nxt = st_r;
    unique case (phase)
      // Quarter one: decode, or swallow the word after a failed test
      bmd_pkg::QP_ONE:
      begin
        if (st_r.skip_pend)
        begin
          st_nxt.op = bmd_pkg::OPK_NONE; // RQ4
          st_nxt.skip_pend = 1'b0;
          st_nxt.skip_nop = 1'b1;
          st_nxt.rd_en = 1'b0; // RQ6
          st_nxt.flags_hold = 1'b0;
          st_nxt.busy = 1'b0; // RQ6
        end
        else
        begin
          st_nxt.op = bmd_op_decode(instr_word[bmd_pkg::OPC_HI:bmd_pkg::OPC_LO]);
          st_nxt.bit_idx = instr_word[bmd_pkg::BIT_HI:bmd_pkg::BIT_LO];
          st_nxt.addr = instr_word[bmd_pkg::ADDR_HI:bmd_pkg::ADDR_LO];
          st_nxt.skip_nop = 1'b0;
          // Ask for the read during quarter two
          st_nxt.rd_en = (st_nxt.op != bmd_pkg::OPK_NONE); // RQ5
          // Bit ops never touch the status flags
          st_nxt.flags_hold = (st_nxt.op != bmd_pkg::OPK_NONE); // RQ9
          // Busy flag follows the decoded class for the whole instruction
          st_nxt.busy = (st_nxt.op != bmd_pkg::OPK_NONE); // RQ1
        end
      end
      // Quarter two: capture the addressed register
      bmd_pkg::QP_TWO:
      begin
        st_nxt.rd_en = 1'b0;
        if (st_r.rd_en)
          st_nxt.data = rf_rd_data; // RQ5
      end
      // Quarter three: modify, or evaluate the tested bit
      bmd_pkg::QP_THREE:
      begin
        unique case (st_r.op)
          bmd_pkg::OPK_SET:
          begin
            st_nxt.wr_data = st_r.data | bmd_bit_mask(st_r.bit_idx); // RQ1
            st_nxt.wr_en = 1'b1; // RQ5
          end
          bmd_pkg::OPK_CLEAR:
          begin
            st_nxt.wr_data = st_r.data & ~bmd_bit_mask(st_r.bit_idx); // RQ10
            st_nxt.wr_en = 1'b1; // RQ5
          end
          bmd_pkg::OPK_TEST:
          begin
            // A clear bit arms the skip; a set bit lets the next word run
            st_nxt.skip_pend = ~|(st_r.data & bmd_bit_mask(st_r.bit_idx)); // RQ3 RQ4
            st_nxt.wr_en = 1'b0; // RQ6
          end
          bmd_pkg::OPK_NONE:
          begin
            st_nxt.wr_en = 1'b0;
          end
          default:
          begin
            st_nxt.wr_en = 1'b0;
          end
        endcase
      end
      // Quarter four: the write strobe shows now; drop it for next cycle
      bmd_pkg::QP_FOUR:
      begin
        st_nxt.wr_en = 1'b0;
      end
      default:
      begin
        st_nxt.rd_en = 1'b0;
        st_nxt.wr_en = 1'b0;
      end
    endcase
  end

  // State register; all flops are static, so ref_clk may be slowed or held
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_r.op <= bmd_pkg::OP_RST;
      st_r.bit_idx <= bmd_pkg::BIT_RST;
      st_r.addr <= bmd_pkg::ADDR_RST;
      st_r.data <= bmd_pkg::DATA_RST;
      st_r.rd_en <= 1'b0;
      st_r.wr_en <= 1'b0;
      st_r.wr_data <= bmd_pkg::DATA_RST;
      st_r.skip_pend <= 1'b0;
      st_r.skip_nop <= 1'b0;
      st_r.flags_hold <= 1'b0; // RQ8
      st_r.busy <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flops
  assign rf_addr = st_r.addr;
  assign rf_rd_en = st_r.rd_en;
  assign rf_wr_en = st_r.wr_en;
  assign rf_wr_data = st_r.wr_data;
  assign flags_hold = st_r.flags_hold;
  assign bit_op_busy = st_r.busy;
  assign skip_nop = st_r.skip_nop;
  assign quarter_phase = phase;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Quarter three of a test whose bit is clear
  sequence s_test_clear;
    phase == bmd_pkg::QP_THREE && st_r.op == bmd_pkg::OPK_TEST &&
      (st_r.data & bmd_bit_mask(st_r.bit_idx)) == 8'h00;
  endsequence

  // Quarter three of a test whose bit is set
  sequence s_test_set;
    phase == bmd_pkg::QP_THREE && st_r.op == bmd_pkg::OPK_TEST &&
      (st_r.data & bmd_bit_mask(st_r.bit_idx)) != 8'h00;
  endsequence

  // A full NOP cycle, quarters two to one
  sequence s_nop_cycle;
    skip_nop [*4] ##1 !skip_nop;
  endsequence

  a_set_write: assert property ( // RQ1
    (phase == bmd_pkg::QP_THREE && st_r.op == bmd_pkg::OPK_SET) |=>
      rf_wr_en && rf_wr_data == ($past(st_r.data) | bmd_bit_mask($past(st_r.bit_idx))))
    else $error("set-bit result wrong");

  a_clear_write: assert property ( // RQ10
    (phase == bmd_pkg::QP_THREE && st_r.op == bmd_pkg::OPK_CLEAR) |=>
      rf_wr_en && rf_wr_data == ($past(st_r.data) & ~bmd_bit_mask($past(st_r.bit_idx))))
    else $error("clear-bit result wrong");

  a_test_nowrite: assert property ( // RQ6
    (st_r.op == bmd_pkg::OPK_TEST || skip_nop) |-> !rf_wr_en)
    else $error("write during test or skip");

  a_skip_taken: assert property ( // RQ4
    s_test_clear |-> ##3 s_nop_cycle)
    else $error("skip cycle missing or wrong length");

  a_no_skip: assert property ( // RQ3
    s_test_set |-> ##3 !skip_nop)
    else $error("skip taken with bit set");

  a_skip_quiet: assert property ( // RQ6
    skip_nop |-> !rf_rd_en && !bit_op_busy)
    else $error("activity during skip cycle");

  a_read_quarter: assert property ( // RQ5
    rf_rd_en |-> phase == bmd_pkg::QP_TWO ##2 (rf_wr_en || st_r.op == bmd_pkg::OPK_TEST))
    else $error("read or write in wrong quarter");

  a_write_quarter: assert property ( // RQ5
    rf_wr_en |-> phase == bmd_pkg::QP_FOUR && $past(rf_rd_en, 2))
    else $error("write not in quarter four");

  a_flags_kept: assert property ( // RQ9
    bit_op_busy |-> flags_hold)
    else $error("status flags not held");

endmodule // bmd_decode

// ===== tb/bmd_decode_bench.sv
/*
  Self-checking bench for bmd_decode: set, clear, test-skip, ignored
  opcodes, quarter-phase rotation, clock halt and reset in mid-run.
  Assumes a same-cycle register read port, played by the bench itself.
*/
`timescale 1ns/1ps
module bmd_decode_bench;
  logic ref_clk, resetn, clk_run;
  logic [13:0] instr_word;
  logic [7:0] rf_rd_data, rf_wr_data;
  logic [6:0] rf_addr;
  logic rf_rd_en, rf_wr_en, flags_hold, bit_op_busy, skip_nop;
  bmd_pkg::bmd_phase_t quarter_phase;
  int fail_count, compares;

  bmd_decode uut (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
    .rf_rd_data(rf_rd_data), .rf_addr(rf_addr), .rf_rd_en(rf_rd_en),
    .rf_wr_en(rf_wr_en), .rf_wr_data(rf_wr_data), .flags_hold(flags_hold),
    .bit_op_busy(bit_op_busy), .skip_nop(skip_nop), .quarter_phase(quarter_phase));

  // Clock halts low when clk_run drops, to show no state is lost
  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      #5;
      if (clk_run)
        ref_clk = ~ref_clk;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One instruction cycle; kind 0 ignored, 1 read-modify-write, 2 test
  // Read data is inverted outside quarter two to catch a late sample
  task automatic run_op(input int kind, input logic [3:0] nib, input logic [2:0] b,
    input logic [6:0] a, input logic [7:0] d, input logic [7:0] wd, input bit pause);
    int i;
    for (i = 0; i < 8 && quarter_phase !== bmd_pkg::QP_ONE; i++)
      @(negedge ref_clk);
    if (i == 8)
    begin
      fail_count++;
      wrap_up();
    end
    instr_word = {nib, b, a};
    rf_rd_data = ~d;
    @(negedge ref_clk);
    rf_rd_data = d;
    check("phase_q2", quarter_phase, bmd_pkg::QP_TWO);
    check("rd_en", rf_rd_en, kind != 0);
    check("busy", bit_op_busy, kind != 0);
    check("flags_hold", flags_hold, kind != 0);
    check("skip_q2", skip_nop, 1'b0);
    if (kind != 0)
      check("addr", rf_addr, a);
    // Halted clock must leave the pending operation intact
    if (pause)
    begin
      clk_run = 1'b0;
      // Off the half-period grid so the restart never races the clock loop
      #703;
      clk_run = 1'b1;
    end
    @(negedge ref_clk);
    rf_rd_data = ~d;
    check("phase_q3", quarter_phase, bmd_pkg::QP_THREE);
    check("rd_en_q3", rf_rd_en, 1'b0);
    @(negedge ref_clk);
    check("phase_q4", quarter_phase, bmd_pkg::QP_FOUR);
    check("wr_en", rf_wr_en, kind == 1);
    if (kind == 1)
      check("wr_data", rf_wr_data, wd);
  endtask

  // All bit positions, set at the top and cleared at the bottom end of the address range
  task automatic t_set_clear();
    run_op(1, bmd_pkg::OPC_SET, 3'h7, 7'h0A, 8'h0A, 8'h8A, 0);
    run_op(1, bmd_pkg::OPC_CLEAR, 3'h7, 7'h0A, 8'hC7, 8'h47, 0);
    for (int b = 0; b < 8; b++)
    begin
      run_op(1, bmd_pkg::OPC_SET, 3'(b), 7'h7F, 8'h00, 8'h01 << b, 0);
      run_op(1, bmd_pkg::OPC_CLEAR, 3'(b), 7'h00, 8'hFF, ~(8'h01 << b), 0);
    end
  endtask

  // Tested bit one: no write, next word runs at once
  task automatic t_test_pass();
    for (int b = 0; b < 8; b++)
    begin
      run_op(2, bmd_pkg::OPC_TEST, 3'(b), 7'h15, 8'h01 << b, 8'h00, 0);
      run_op(1, bmd_pkg::OPC_SET, 3'(b), 7'h15, 8'h00, 8'h01 << b, 0);
    end
  endtask

  // Tested bit zero: fetched word dropped, a whole idle cycle follows
  task automatic t_test_skip();
    for (int b = 0; b < 8; b++)
    begin
      run_op(2, bmd_pkg::OPC_TEST, 3'(b), 7'h2A, ~(8'h01 << b), 8'h00, 0);
      @(negedge ref_clk);
      instr_word = {bmd_pkg::OPC_SET, 3'(b), 7'h2A};
      repeat (4)
      begin
        @(negedge ref_clk);
        check("skip_nop", skip_nop, 1'b1);
        check("skip_rd", rf_rd_en, 1'b0);
        check("skip_wr", rf_wr_en, 1'b0);
        check("skip_busy", bit_op_busy, 1'b0);
      end
    end
    run_op(1, bmd_pkg::OPC_CLEAR, 3'h2, 7'h2A, 8'h04, 8'h00, 0);
  endtask

  // Other top nibbles must not touch the register file
  task automatic t_ignored();
    for (int n = 0; n < 16; n++)
      if (n < 4 || n > 6)
        run_op(0, 4'(n), 3'h5, 7'h33, 8'hA5, 8'h00, 0);
  endtask

  // Reset during quarter two drops the operation and restarts phases
  task automatic t_mid_reset();
    run_op(1, bmd_pkg::OPC_SET, 3'h3, 7'h40, 8'h00, 8'h08, 1);
    @(negedge ref_clk);
    instr_word = {bmd_pkg::OPC_SET, 3'h1, 7'h40};
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (3)
    begin
      @(negedge ref_clk);
      check("rst_phase", quarter_phase, bmd_pkg::QP_FOUR);
      check("rst_wr", rf_wr_en, 1'b0);
    end
    resetn = 1'b1;
    run_op(1, bmd_pkg::OPC_CLEAR, 3'h6, 7'h40, 8'h40, 8'h00, 0);
  endtask

  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    resetn = 1'b0;
    clk_run = 1'b1;
    instr_word = 14'h0000;
    rf_rd_data = 8'h00;
    fail_count = 0;
    compares = 0;
    repeat (12) @(negedge ref_clk);
    check("init_phase", quarter_phase, bmd_pkg::QP_FOUR);
    check("init_busy", bit_op_busy, 1'b0);
    resetn = 1'b1;
    t_set_clear();
    t_test_pass();
    t_test_skip();
    t_ignored();
    t_mid_reset();
    wrap_up();
  end
endmodule // bmd_decode_bench
